// ==== core/free_running_timer_capture.sv ====
// 16-bit free-running counter, overflow flag and two input-capture channels
// assumes: one cpu clock, byte register port with read data one cycle after the strobe
//
// Overview of operation
// - count on cpu clock divided by 2, 4, 8
// - full 65536 wrap per prescale ratio
// - main and alternate pairs show same count
// - low byte write reloads counter to FFFCh
// - high byte read buffers low byte
// - buffer frozen until low byte read
// - lone low read returns live low byte
// - wrap FFFFh to 0000h sets overflow flag
// - overflow irq needs enable and mask clear
// - clear overflow: status read, then main low access
// - alternate low access never clears overflow
// - counter keeps running in cpu wait
// - both select bits pick external clock
// - edge select picks external clock polarity
// - counter updates on cpu clock only
// - capture latches count on active edge
// - capture registers ignore writes
// - per-channel edge select for captures
// - capture sets flag, gated irq request
// - capture high read blocks until low read
`include "timer_map.svh"
`timescale 1ns/100ps
`default_nettype none

module free_running_timer_capture #(
  parameter int CH = 2
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic [`ADDR_W-1:0]   addr,
  input  wire logic [7:0]           wdata,
  input  wire logic                 wr,
  input  wire logic                 rd,
  output logic      [7:0]           rdata,
  input  wire logic                 cpu_irq_mask,
  input  wire logic                 cpu_wait,
  input  wire logic                 ext_clock_pin,
  input  wire logic [CH-1:0]        capture_input_pin,
  output logic                      timer_irq
);

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  logic [7:0] control_reg_a_q;
  logic [7:0] control_reg_b_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      control_reg_a_q <= `CTRL_RESET;
      control_reg_b_q <= `CTRL_RESET;
    end else if (wr && addr == `OFF_CTRL_A) begin
      control_reg_a_q <= wdata;
    end else if (wr && addr == `OFF_CTRL_B) begin
      control_reg_b_q <= wdata;
    end
  end

  logic             overflow_irq_enable;
  logic             capture_irq_enable;
  logic             ext_clock_edge_select;
  logic [CH-1:0]    capture_edge_select;
  timer_pkg::clk_sel_t clk_sel;

  assign overflow_irq_enable   = control_reg_a_q[`CA_OVF_IRQ_EN];
  assign capture_irq_enable    = control_reg_a_q[`CA_CAP_IRQ_EN];
  assign ext_clock_edge_select = control_reg_b_q[`CB_EXT_EDGE];
  assign clk_sel = timer_pkg::clk_sel_t'({control_reg_b_q[`CB_CLK_SEL_HI],
                                          control_reg_b_q[`CB_CLK_SEL_LO]});
  assign capture_edge_select[0] = control_reg_a_q[`CA_EDGE1];
  assign capture_edge_select[1] = control_reg_b_q[`CB_EDGE2];

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  // three stages; an edge counts once stages two and three disagree
  logic [2:0]       ext_sync_q;
  logic [2:0]       cap_sync_q [CH];
  logic             ext_edge;
  logic [CH-1:0]    cap_edge;

  always_ff @(posedge clk) begin
    if (rst) begin
      ext_sync_q <= 3'h0;
    end else begin
      ext_sync_q <= {ext_sync_q[1:0], ext_clock_pin};
    end
  end

  // edge select high means rising
  assign ext_edge = ext_clock_edge_select ? (ext_sync_q[1] & ~ext_sync_q[2])
                                          : (~ext_sync_q[1] & ext_sync_q[2]);

  // ----------------------------------------------------------------
  // prescaler and counter
  // ----------------------------------------------------------------
  // the cpu wait input is deliberately not looked at: counting goes on
  logic [`PRESC_W-1:0] presc_q;
  logic [`PRESC_W-1:0] presc_mask;
  logic                tick;
  logic [15:0]         count_q;
  logic                wrap;
  logic                cnt_lo_wr;

  always_comb begin
    case (clk_sel)
      timer_pkg::CLK_DIV2: presc_mask = `PRESC_MASK_DIV2;
      timer_pkg::CLK_DIV4: presc_mask = `PRESC_MASK_DIV4;
      timer_pkg::CLK_DIV8: presc_mask = `PRESC_MASK_DIV8;
      default:             presc_mask = `PRESC_MASK_DIV2;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      presc_q <= '0;
    end else begin
      presc_q <= presc_q + 1'b1;
    end
  end

  // ext edges are resynchronised to clk, so no other clock drives the count
  assign tick = (clk_sel == timer_pkg::CLK_EXT) ? ext_edge
                                                : ((presc_q & presc_mask) == presc_mask);
  assign cnt_lo_wr = wr && (addr == `OFF_CNT_LO || addr == `OFF_ALT_CNT_LO);
  assign wrap = tick && !cnt_lo_wr && count_q == `CNT_MAX;

  always_ff @(posedge clk) begin
    if (rst) begin
      count_q <= `CNT_RESET;
    end else if (cnt_lo_wr) begin
      count_q <= `CNT_RELOAD;
    end else if (tick) begin
      count_q <= count_q + 16'h1;
    end
  end

  // ----------------------------------------------------------------
  // coherent two-byte counter read
  // ----------------------------------------------------------------
  logic [7:0] lo_buf_q;
  logic       lo_held_q;
  logic       cnt_hi_rd;
  logic       cnt_lo_rd;

  assign cnt_hi_rd = rd && (addr == `OFF_CNT_HI || addr == `OFF_ALT_CNT_HI);
  assign cnt_lo_rd = rd && (addr == `OFF_CNT_LO || addr == `OFF_ALT_CNT_LO);

  always_ff @(posedge clk) begin
    if (rst) begin
      lo_held_q <= 1'b0;
      lo_buf_q  <= 8'h00;
    end else if (cnt_lo_rd) begin
      lo_held_q <= 1'b0;
    end else if (cnt_hi_rd && !lo_held_q) begin
      lo_held_q <= 1'b1;
      lo_buf_q  <= count_q[7:0];
    end
  end

  // ----------------------------------------------------------------
  // overflow flag
  // ----------------------------------------------------------------
  logic overflow_flag_q;
  logic ovf_armed_q;
  logic status_rd;
  logic main_lo_access;

  assign status_rd      = rd && addr == `OFF_STATUS;
  // only the main low byte clears; the alternate pair is left out on purpose
  assign main_lo_access = (rd || wr) && addr == `OFF_CNT_LO;

  always_ff @(posedge clk) begin
    if (rst) begin
      overflow_flag_q <= 1'b0;
    end else if (wrap) begin
      overflow_flag_q <= 1'b1;
    end else if (ovf_armed_q && main_lo_access) begin
      overflow_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ovf_armed_q <= 1'b0;
    end else if (status_rd && overflow_flag_q) begin
      ovf_armed_q <= 1'b1;
    end else if (main_lo_access || !overflow_flag_q) begin
      ovf_armed_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // capture channels
  // ----------------------------------------------------------------
  logic [15:0]   capture_value_q [CH];
  logic [CH-1:0] capture_flag_q;
  logic [CH-1:0] cap_armed_q;
  logic [CH-1:0] cap_block_q;
  logic [CH-1:0] cap_hi_rd;
  logic [CH-1:0] cap_lo_acc;
  logic [CH-1:0] cap_lo_rd;

  for (genvar i = 0; i < CH; i++) begin : g_cap
    localparam logic [`ADDR_W-1:0] HI = (i == 0) ? `OFF_CAP1_HI : `OFF_CAP2_HI;
    localparam logic [`ADDR_W-1:0] LO = (i == 0) ? `OFF_CAP1_LO : `OFF_CAP2_LO;

    assign cap_hi_rd[i]  = rd && addr == HI;
    assign cap_lo_rd[i]  = rd && addr == LO;
    assign cap_lo_acc[i] = (rd || wr) && addr == LO;
    assign cap_edge[i]   = capture_edge_select[i]
                           ? (cap_sync_q[i][1] & ~cap_sync_q[i][2])
                           : (~cap_sync_q[i][1] & cap_sync_q[i][2]);

    always_ff @(posedge clk) begin
      if (rst) begin
        cap_sync_q[i] <= 3'h0;
      end else begin
        cap_sync_q[i] <= {cap_sync_q[i][1:0], capture_input_pin[i]};
      end
    end

    // writes never reach the value register
    always_ff @(posedge clk) begin
      if (rst) begin
        capture_value_q[i] <= 16'h0000;
      end else if (cap_edge[i] && !cap_block_q[i]) begin
        capture_value_q[i] <= count_q;
      end
    end

    always_ff @(posedge clk) begin
      if (rst) begin
        cap_block_q[i] <= 1'b0;
      end else if (cap_lo_rd[i]) begin
        cap_block_q[i] <= 1'b0;
      end else if (cap_hi_rd[i]) begin
        cap_block_q[i] <= 1'b1;
      end
    end

    always_ff @(posedge clk) begin
      if (rst) begin
        capture_flag_q[i] <= 1'b0;
      end else if (cap_edge[i]) begin
        capture_flag_q[i] <= 1'b1;
      end else if (cap_armed_q[i] && cap_lo_acc[i]) begin
        capture_flag_q[i] <= 1'b0;
      end
    end

    always_ff @(posedge clk) begin
      if (rst) begin
        cap_armed_q[i] <= 1'b0;
      end else if (status_rd && capture_flag_q[i]) begin
        cap_armed_q[i] <= 1'b1;
      end else if (cap_lo_acc[i] || !capture_flag_q[i]) begin
        cap_armed_q[i] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt request
  // ----------------------------------------------------------------
  // request stays pending in the flags until the cpu mask opens
  assign timer_irq = !cpu_irq_mask && ((overflow_irq_enable && overflow_flag_q)
                     || (capture_irq_enable && |capture_flag_q));

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  logic [7:0] rdata_d;
  logic [7:0] status_val;

  always_comb begin
    status_val = 8'h00;
    status_val[`ST_CAP1] = capture_flag_q[0];
    status_val[`ST_CAP2] = capture_flag_q[1];
    status_val[`ST_OVF]  = overflow_flag_q;
  end

  always_comb begin
    case (addr)
      `OFF_CTRL_A:     rdata_d = control_reg_a_q;
      `OFF_CTRL_B:     rdata_d = control_reg_b_q;
      `OFF_STATUS:     rdata_d = status_val;
      `OFF_CAP1_HI:    rdata_d = capture_value_q[0][15:8];
      `OFF_CAP1_LO:    rdata_d = capture_value_q[0][7:0];
      `OFF_CAP2_HI:    rdata_d = capture_value_q[1][15:8];
      `OFF_CAP2_LO:    rdata_d = capture_value_q[1][7:0];
      `OFF_CNT_HI,
      `OFF_ALT_CNT_HI: rdata_d = count_q[15:8];
      `OFF_CNT_LO,
      `OFF_ALT_CNT_LO: rdata_d = lo_held_q ? lo_buf_q : count_q[7:0];
      default:         rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (rd) begin
      rdata <= rdata_d;
    end else begin
      rdata <= 8'h00;
    end
  end

endmodule

`default_nettype wire

// ==== core/timer_map.svh ====
// register offsets, field positions, reset values and counts for the capture timer
// assumes: included by the timer module, the bench and the checker, byte-wide register port
`ifndef TIMER_MAP_SVH
`define TIMER_MAP_SVH
`define ADDR_W            4
`define OFF_CTRL_A        4'h0
`define OFF_CTRL_B        4'h1
`define OFF_STATUS        4'h2
`define OFF_CAP1_HI       4'h3
`define OFF_CAP1_LO       4'h4
`define OFF_CAP2_HI       4'h5
`define OFF_CAP2_LO       4'h6
`define OFF_CNT_HI        4'h7
`define OFF_CNT_LO        4'h8
`define OFF_ALT_CNT_HI    4'h9
`define OFF_ALT_CNT_LO    4'hA
// control_reg_a fields
`define CA_CAP_IRQ_EN     7
`define CA_OVF_IRQ_EN     5
`define CA_EDGE1          1
// control_reg_b fields
`define CB_CLK_SEL_HI     3
`define CB_CLK_SEL_LO     2
`define CB_EDGE2          1
`define CB_EXT_EDGE       0
// timer_status_reg fields
`define ST_CAP1           7
`define ST_OVF            5
`define ST_CAP2           4
`define CNT_RELOAD        16'hFFFC
`define CNT_RESET         16'hFFFC
`define CNT_MAX           16'hFFFF
`define CTRL_RESET        8'h00
`define PRESC_W           3
`define PRESC_MASK_DIV2   3'h1
`define PRESC_MASK_DIV4   3'h3
`define PRESC_MASK_DIV8   3'h7
`endif

// ==== core/timer_pkg.sv ====
// types for the free-running timer with input capture
// assumes: timer_map.svh sits beside it
package timer_pkg;
  typedef enum logic [1:0] {
    CLK_DIV4,
    CLK_DIV8,
    CLK_DIV2,
    CLK_EXT
  } clk_sel_t;
endpackage

// ==== dv/ext_clock_source.sv ====
// external count clock source standing at the timer's clock pin
// assumes: bench clock, run held high for a whole burst
`timescale 1ns/100ps
`default_nettype none
module ext_clock_source #(parameter int HALF = 5) (
  input  wire logic       clk,
  input  wire logic       run,
  output logic            pin,
  output logic [7:0]      rises,
  output logic [7:0]      falls
);
  int cnt = 0;
  initial begin
    pin = 1'b0;
    rises = 8'h00;
    falls = 8'h00;
  end
  // HALF cycles a level keeps active edges well over four cpu edges apart
  always @(posedge clk) begin
    if (run) begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1) begin
        pin <= !pin;
        if (pin) falls <= falls + 8'h01;
        else rises <= rises + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ==== dv/free_running_timer_capture_tb.sv ====
// self-checking bench for the capture timer
// assumes: checker bound, ext_clock_source on the count clock pin
`include "timer_map.svh"
`timescale 1ns/100ps
`default_nettype none
module free_running_timer_capture_tb;
  typedef struct packed {logic w; logic [`ADDR_W-1:0] a; logic [7:0] d;} bus_op_t;
  logic               clk, rst, wr, rd, cpu_irq_mask, cpu_wait, run, ext_pin, timer_irq;
  logic [`ADDR_W-1:0] addr;
  logic [7:0]         wdata, rdata, rises, falls, r0;
  logic [7:0]         res [9];
  logic [7:0]         sel [3] = '{8'h08, 8'h00, 8'h04};
  logic [1:0]         cap;
  logic [15:0]        c0;
  bus_op_t            q [10];
  int                 dv [3] = '{2, 4, 8};
  int                 n_op, bad_count, n_compared;
  free_running_timer_capture i_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .cpu_irq_mask(cpu_irq_mask), .cpu_wait(cpu_wait),
    .ext_clock_pin(ext_pin), .capture_input_pin(cap), .timer_irq(timer_irq));
  ext_clock_source i_ext (.clk(clk), .run(run), .pin(ext_pin), .rises(rises), .falls(falls));
  initial begin
    clk = 1'b0;
    forever #2 clk = !clk;
  end
  // ----------------------------------------
  // bus tasks and compares
  // ----------------------------------------
  task automatic op(input logic w, input logic [`ADDR_W-1:0] a, input logic [7:0] d = 8'h00);
    q[n_op] = '{w, a, d};
    n_op++;
  endtask
  task automatic rdc();
    op(0, `OFF_CNT_HI);
    op(0, `OFF_CNT_LO);
  endtask
  // strobes back to back; each answer is taken mid-cycle while the next request stands
  task automatic go();
    for (int i = 0; i <= n_op; i++) begin
      wr <= i < n_op && q[i].w;
      rd <= i < n_op && !q[i].w;
      addr <= q[i].a;
      wdata <= q[i].d;
      @(negedge clk);
      if (i > 0) res[i-1] = rdata;
      @(posedge clk);
    end
    n_op = 0;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic [7:0] got, input logic [7:0] exp);
    chk({8'h00, got}, {8'h00, exp});
  endtask
  task automatic chk_irq(input logic exp);
    @(negedge clk);
    chk({15'h0000, timer_irq}, {15'h0000, exp});
    @(posedge clk);
  endtask
  task automatic finish_test();
    $display("compared %0d bad %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    {rst, wr, rd, cpu_irq_mask, cpu_wait, run, addr, wdata, cap} = '0;
    rst = 1'b1;
    cpu_irq_mask = 1'b1;
    n_op = 0;
    bad_count = 0;
    n_compared = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 7; i++) op(0, `ADDR_W'(i));
    op(0, '1);
    op(0, `OFF_CNT_HI);
    go();
    for (int i = 0; i < 8; i++) chkb(res[i], 8'h00);
    chkb(res[8], 8'hFF);
    // close the pair opened above, else the first prescale pair reads a stale low byte
    op(0, `OFF_CNT_LO);
    go();
    chkb(res[0], 8'hFE);
    $display("reset test done");
    cpu_wait <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      op(1, `OFF_CTRL_B, sel[k]);
      op(1, `OFF_CNT_LO);
      go();
      rdc();
      rdc();
      go();
      c0 = {res[0], res[1]};
      repeat (64 * dv[k] - 5) @(posedge clk);
      rdc();
      go();
      chk({res[0], res[1]} - c0, 16'h0040);
    end
    $display("prescale test done");
    op(1, `OFF_CTRL_A, 8'h20);
    op(0, `OFF_STATUS);
    go();
    chkb(res[1], 8'h20);
    chk_irq(1'b0);
    cpu_irq_mask <= 1'b0;
    chk_irq(1'b1);
    op(1, `OFF_ALT_CNT_LO);
    op(0, `OFF_ALT_CNT_HI);
    go();
    chkb(res[1], 8'hFF);
    chk_irq(1'b1);
    op(0, `OFF_STATUS);
    op(1, `OFF_CNT_LO);
    op(0, `OFF_CNT_HI);
    op(0, `OFF_STATUS);
    op(0, `OFF_CNT_LO);
    go();
    chkb(res[2], 8'hFF);
    chkb(res[3], 8'h00);
    chkb(res[4], 8'hFC);
    chk_irq(1'b0);
    $display("overflow test done");
    cpu_irq_mask <= 1'b1;
    op(1, `OFF_CTRL_A, 8'h00);
    go();
    for (int e = 0; e < 2; e++) begin
      op(1, `OFF_CTRL_B, 8'h0C | 8'(e));
      rdc();
      go();
      c0 = {res[1], res[2]};
      r0 = e ? rises : falls;
      run <= 1'b1;
      repeat (52) @(posedge clk);
      run <= 1'b0;
      repeat (12) @(posedge clk);
      rdc();
      go();
      chk({res[0], res[1]} - c0, {8'h00, (e ? rises : falls) - r0});
    end
    c0 = {res[0], res[1]};
    $display("external clock test done");
    cpu_irq_mask <= 1'b0;
    op(1, `OFF_CTRL_A, 8'h82);
    go();
    cap <= 2'b11;
    repeat (8) @(posedge clk);
    chk_irq(1'b1);
    op(0, `OFF_STATUS);
    op(0, `OFF_CAP1_HI);
    op(0, `OFF_CAP1_LO);
    op(1, `OFF_CAP1_HI, 8'h55);
    op(0, `OFF_CAP1_HI);
    op(0, `OFF_CAP2_HI);
    // low read lifts the block that the high read set, so the next capture lands
    op(0, `OFF_CAP2_LO);
    go();
    chkb(res[0], 8'hA0);
    chk({res[1], res[2]}, c0);
    chkb(res[4], c0[15:8]);
    chkb(res[5], 8'h00);
    chkb(res[6], 8'h00);
    chk_irq(1'b0);
    cap <= 2'b00;
    repeat (8) @(posedge clk);
    op(0, `OFF_STATUS);
    op(0, `OFF_CAP2_HI);
    op(0, `OFF_CAP2_LO);
    go();
    chkb(res[0], 8'h30);
    chk({res[1], res[2]}, c0);
    $display("capture test done");
    finish_test();
  end
endmodule
`default_nettype wire

// ==== dv/timer_sva.sv ====
// port checker for the capture timer
// assumes: bound into free_running_timer_capture, one clock domain
`include "timer_map.svh"
`timescale 1ns/100ps
`default_nettype none
module timer_sva #(parameter int CH = 2) (
  input wire logic               clk,
  input wire logic               rst,
  input wire logic [`ADDR_W-1:0] addr,
  input wire logic [7:0]         wdata,
  input wire logic               wr,
  input wire logic               rd,
  input wire logic [7:0]         rdata,
  input wire logic               cpu_irq_mask,
  input wire logic               cpu_wait,
  input wire logic               ext_clock_pin,
  input wire logic [CH-1:0]      capture_input_pin,
  input wire logic               timer_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // accesses that may legally drop the request
  // ----------------------------------------
  logic clr_cause;
  assign clr_cause = (rd || wr) && (addr == `OFF_CNT_LO || addr == `OFF_CAP1_LO
    || addr == `OFF_CAP2_LO) || wr && addr == `OFF_CTRL_A;
  property p_idle; !$past(rd) |-> rdata == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("read data outside answer cycle");
  property p_unmap; rd && addr > `OFF_ALT_CNT_LO |=> rdata == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_mask; cpu_irq_mask |-> !timer_irq; endproperty
  a_mask: assert property (p_mask) else $error("request while masked");
  property p_rld; wr && addr == `OFF_CNT_LO ##1 rd && addr == `OFF_CNT_HI |=> rdata == 8'hFF;
  endproperty
  a_rld: assert property (p_rld) else $error("main reload wrong");
  property p_arld;
    wr && addr == `OFF_ALT_CNT_LO ##1 rd && addr == `OFF_ALT_CNT_HI |=> rdata == 8'hFF;
  endproperty
  a_arld: assert property (p_arld) else $error("alternate reload wrong");
  property p_alt;
    timer_irq && !cpu_irq_mask && (rd || wr) && addr == `OFF_ALT_CNT_LO ##1 !cpu_irq_mask
      |-> timer_irq;
  endproperty
  a_alt: assert property (p_alt) else $error("alternate access dropped request");
  property p_clr; $fell(timer_irq) && !cpu_irq_mask && !$past(cpu_irq_mask) |-> $past(clr_cause);
  endproperty
  a_clr: assert property (p_clr) else $error("request dropped without cause");
  // two back-to-back pair reads two cycles apart differ by one count at most
  property p_step;
    rd && addr == `OFF_CNT_HI ##1 rd && addr == `OFF_CNT_LO ##1 rd && addr == `OFF_CNT_HI
      ##1 rd && addr == `OFF_CNT_LO
      |=> 16'({$past(rdata), rdata} - {$past(rdata, 3), $past(rdata, 2)}) <= 16'h0001;
  endproperty
  a_step: assert property (p_step) else $error("pair reads incoherent");
endmodule
bind free_running_timer_capture timer_sva #(.CH(CH)) i_sva (.clk(clk), .rst(rst),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .cpu_irq_mask(cpu_irq_mask),
  .cpu_wait(cpu_wait), .ext_clock_pin(ext_clock_pin),
  .capture_input_pin(capture_input_pin), .timer_irq(timer_irq));
`default_nettype wire
